// [core/shared_res_pkg.sv]
// Purpose: Constants and carrier types of the dual-side shared resource fabric.
// Assumes: One clock, one synchronous reset; depths sized for flip-flop storage.
// Notes: Region codes select what a side request addresses.
package shared_res_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int MSG_DEPTH = 8;
   localparam int SH_BLOCKS = 8;
   localparam int SH_DEPTH = 4;
   localparam int MEM_WORDS = 2 * MSG_DEPTH + SH_BLOCKS * SH_DEPTH;
   localparam int CHANNELS = 32;
   localparam int IRQ_CH = 4;
   localparam int EOC_N = 8;
   localparam int N_EV = 4;
   // ----------------------------------------
   // Regions and storage bases
   // ----------------------------------------
   localparam logic [2:0] RG_M2C = 3'h0;
   localparam logic [2:0] RG_C2M = 3'h1;
   localparam logic [2:0] RG_SHR = 3'h2;
   localparam logic [2:0] RG_HS = 3'h3;
   localparam logic [2:0] RG_ANA_RES = 3'h4;
   localparam logic [2:0] RG_ANA_REG = 3'h5;
   localparam logic [5:0] MEM_C2M_BASE = 6'h08;
   localparam logic [5:0] MEM_SHR_BASE = 6'h10;
   // ----------------------------------------
   // Register map and events
   // ----------------------------------------
   localparam logic [7:0] OFS_DIR = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_MASK = 8'h0c;
   localparam logic [7:0] OFS_FLAGS_M2C = 8'h10;
   localparam logic [7:0] OFS_FLAGS_C2M = 8'h14;
   localparam logic [7:0] OFS_EOC = 8'h18;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int EV_M_PAR = 0;
   localparam int EV_C_PAR = 1;
   localparam int EV_M_DENY = 2;
   localparam int EV_C_DENY = 3;
   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic req; logic we; logic dma; logic [2:0] region; logic [4:0] idx; logic [31:0] wdata;
   } side_req_t;
   typedef struct packed {logic ack; logic err; logic fault; logic [31:0] rdata;} side_rsp_t;
   typedef struct packed {logic req; logic we; logic res; logic [4:0] addr; logic [31:0] wdata;} ana_req_t;
   typedef struct packed {
      logic [MEM_WORDS-1:0][32:0] mem;
      logic [SH_BLOCKS-1:0] dir;
      logic inject;
      logic [1:0][CHANNELS-1:0] hs;
      logic [N_EV-1:0] sts;
      logic [N_EV-1:0] mask;
      logic irq;
      logic [EOC_N-1:0] eoc;
      side_rsp_t [1:0] rsp;
      ana_req_t ana;
      logic busy; logic owner; logic rr;
      logic awr; logic wr; logic arr; logic aw_got; logic w_got; logic bv; logic rv;
      logic [7:0] aw_a; logic [31:0] wd; logic [3:0] ws;
      logic [1:0] bresp; logic [1:0] rresp; logic [31:0] rd;
   } state_t;
endpackage : shared_res_pkg

// [core/shared_res.sv]
// Purpose: Shared message RAMs, shared RAM blocks, handshake flags and analog bus arbiter.
// Assumes: Side requesters hold req until ack and drop it the cycle after ack.
// Notes: Side 0 is the master subsystem, side 1 the control subsystem.
//
// Operation
// R01: Master-to-control RAM: master writes, control reads only
// R02: Control-to-master RAM: control writes, master reads only
// R03: Thirty-two pollable handshake channels
// R04: Four channels drive interrupts on both sides
// R05: Shared blocks one-way, direction set per block
// R06: Parity checked on all stored words
// R07: Handshake refused to control-side DMA
// R08: Converter results readable by every requester
// R09: Other analog registers: control CPU only
// R10: Analog bus arbitrates between both sides
// R11: Conversion-done sources ANDed, sent to both
// R12: Master-side parity error raises bus fault
// R13: Sender sets flag, receiver acknowledges to clear
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
module shared_res (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Side requests and answers
   input shared_res_pkg::side_req_t m_req,
   input shared_res_pkg::side_req_t c_req,
   output shared_res_pkg::side_rsp_t m_rsp,
   output shared_res_pkg::side_rsp_t c_rsp,
   // Handshake interrupts
   output logic [shared_res_pkg::IRQ_CH-1:0] master_irq_controller_irq,
   output logic [shared_res_pkg::IRQ_CH-1:0] control_irq_expander_irq,
   // Analog common bus
   output shared_res_pkg::ana_req_t ana_out,
   input wire logic [31:0] ana_rdata,
   input wire logic [shared_res_pkg::EOC_N-1:0] adc1_eoc,
   input wire logic [shared_res_pkg::EOC_N-1:0] adc2_eoc,
   output logic [shared_res_pkg::EOC_N-1:0] eoc_master,
   output logic [shared_res_pkg::EOC_N-1:0] eoc_control,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq
);
   shared_res_pkg::state_t state_reg;
   shared_res_pkg::state_t state_next;
   shared_res_pkg::side_req_t [1:0] rq;

   assign rq[0] = m_req;
   assign rq[1] = c_req;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [5:0] wi;
      logic own;
      logic [32:0] word;
      logic [1:0] want;
      logic g;
      logic [1:0][31:0] set_v;
      logic [1:0][31:0] clr_v;
      logic [shared_res_pkg::N_EV-1:0] ev;
      logic [shared_res_pkg::N_EV-1:0] w1c;
      logic [31:0] m;
      wi = '0;
      own = 1'b0;
      word = '0;
      want = '0;
      g = 1'b0;
      set_v = '0;
      clr_v = '0;
      ev = '0;
      w1c = '0;
      m = {{8{state_reg.ws[3]}}, {8{state_reg.ws[2]}}, {8{state_reg.ws[1]}}, {8{state_reg.ws[0]}}};
      state_next = state_reg;
      for (int i = 0; i < 2; i++) begin
         state_next.rsp[i].ack = 1'b0;
         state_next.rsp[i].err = 1'b0;
         state_next.rsp[i].fault = 1'b0;
      end
      state_next.eoc = adc1_eoc & adc2_eoc; // see R11
      for (int i = 0; i < 2; i++) begin
         if (rq[i].req && !state_reg.rsp[i].ack) begin
            case (rq[i].region)
               shared_res_pkg::RG_M2C, shared_res_pkg::RG_C2M, shared_res_pkg::RG_SHR: begin
                  state_next.rsp[i].ack = 1'b1;
                  state_next.rsp[i].rdata = '0;
                  if (rq[i].region == shared_res_pkg::RG_M2C) begin
                     wi = {3'h0, rq[i].idx[2:0]};
                     own = (i == 0); // see R01
                  end else if (rq[i].region == shared_res_pkg::RG_C2M) begin
                     wi = shared_res_pkg::MEM_C2M_BASE + {3'h0, rq[i].idx[2:0]};
                     own = (i == 1); // see R02
                  end else begin
                     wi = shared_res_pkg::MEM_SHR_BASE + {1'b0, rq[i].idx};
                     own = state_reg.dir[rq[i].idx[4:2]] ? (i == 1) : (i == 0); // see R05
                  end
                  word = state_reg.mem[wi];
                  if (rq[i].we) begin
                     if (own) begin
                        state_next.mem[wi] = {(^rq[i].wdata) ^ state_reg.inject, rq[i].wdata}; // see R06
                     end else begin
                        state_next.rsp[i].err = 1'b1;
                        ev[shared_res_pkg::EV_M_DENY + i] = 1'b1;
                     end
                  end else begin
                     state_next.rsp[i].rdata = word[31:0];
                     if (^word) begin // see R06
                        state_next.rsp[i].err = 1'b1;
                        state_next.rsp[i].fault = (i == 0); // see R12
                        ev[shared_res_pkg::EV_M_PAR + i] = 1'b1;
                     end
                  end
               end
               shared_res_pkg::RG_HS: begin
                  state_next.rsp[i].ack = 1'b1;
                  if (i == 1 && rq[i].dma) begin // see R07
                     state_next.rsp[i].err = 1'b1;
                     state_next.rsp[i].rdata = '0;
                     ev[shared_res_pkg::EV_C_DENY] = 1'b1;
                  end else begin
                     state_next.rsp[i].rdata = rq[i].idx[0] ? state_reg.hs[1 - i] : state_reg.hs[i]; // see R03
                     if (rq[i].we && !rq[i].idx[0]) begin
                        set_v[i] = rq[i].wdata; // see R13
                     end else if (rq[i].we) begin
                        clr_v[1 - i] = rq[i].wdata; // see R13
                     end
                  end
               end
               shared_res_pkg::RG_ANA_RES, shared_res_pkg::RG_ANA_REG: begin
                  if ((rq[i].region == shared_res_pkg::RG_ANA_RES && !rq[i].we) || // see R08
                      (i == 1 && !rq[i].dma)) begin // see R09
                     want[i] = 1'b1;
                  end else begin
                     state_next.rsp[i].ack = 1'b1;
                     state_next.rsp[i].err = 1'b1;
                     state_next.rsp[i].rdata = '0;
                     ev[shared_res_pkg::EV_M_DENY + i] = 1'b1;
                  end
               end
               default: begin
                  state_next.rsp[i].ack = 1'b1;
                  state_next.rsp[i].err = 1'b1;
                  state_next.rsp[i].rdata = '0;
                  ev[shared_res_pkg::EV_M_DENY + i] = 1'b1;
               end
            endcase
         end
      end
      // Set applied after clear so a same-cycle set survives
      for (int k = 0; k < 2; k++) begin
         state_next.hs[k] = (state_reg.hs[k] & ~clr_v[k]) | set_v[k]; // see R13
      end
      // One analog access at a time; round robin on contention
      state_next.ana.req = 1'b0;
      if (state_reg.busy) begin
         state_next.busy = 1'b0;
         state_next.rsp[state_reg.owner].ack = 1'b1;
         state_next.rsp[state_reg.owner].rdata = ana_rdata;
      end else if (|want) begin
         g = want[1] && (!want[0] || state_reg.rr); // see R10
         state_next.rr = ~g;
         state_next.owner = g;
         state_next.busy = 1'b1;
         state_next.ana.req = 1'b1;
         state_next.ana.we = rq[g].we;
         state_next.ana.res = (rq[g].region == shared_res_pkg::RG_ANA_RES);
         state_next.ana.addr = rq[g].idx;
         state_next.ana.wdata = rq[g].wdata;
      end
      // AXI write channel
      if (state_reg.bv && s_axi_bready) begin
         state_next.bv = 1'b0;
      end
      if (s_axi_awvalid && state_reg.awr) begin
         state_next.aw_got = 1'b1;
         state_next.aw_a = s_axi_awaddr;
      end
      if (s_axi_wvalid && state_reg.wr) begin
         state_next.w_got = 1'b1;
         state_next.wd = s_axi_wdata;
         state_next.ws = s_axi_wstrb;
      end
      if (state_reg.aw_got && state_reg.w_got && !state_reg.bv) begin
         state_next.aw_got = 1'b0;
         state_next.w_got = 1'b0;
         state_next.bv = 1'b1;
         state_next.bresp = shared_res_pkg::RESP_OKAY;
         case (state_reg.aw_a)
            shared_res_pkg::OFS_DIR: state_next.dir = (state_reg.dir & ~m[7:0]) | (state_reg.wd[7:0] & m[7:0]);
            shared_res_pkg::OFS_CTRL: if (m[0]) state_next.inject = state_reg.wd[0];
            shared_res_pkg::OFS_STATUS: w1c = state_reg.wd[shared_res_pkg::N_EV-1:0] & m[shared_res_pkg::N_EV-1:0];
            shared_res_pkg::OFS_MASK: begin
               state_next.mask = (state_reg.mask & ~m[shared_res_pkg::N_EV-1:0]) |
                                 (state_reg.wd[shared_res_pkg::N_EV-1:0] & m[shared_res_pkg::N_EV-1:0]);
            end
            default: state_next.bresp = shared_res_pkg::RESP_SLVERR;
         endcase
      end
      state_next.sts = (state_reg.sts & ~w1c) | ev;
      state_next.irq = |(state_next.sts & state_next.mask);
      // AXI read channel
      if (state_reg.rv && s_axi_rready) begin
         state_next.rv = 1'b0;
      end
      if (s_axi_arvalid && state_reg.arr) begin
         state_next.rv = 1'b1;
         state_next.rresp = shared_res_pkg::RESP_OKAY;
         case (s_axi_araddr)
            shared_res_pkg::OFS_DIR: state_next.rd = {24'h000000, state_reg.dir};
            shared_res_pkg::OFS_CTRL: state_next.rd = {31'h00000000, state_reg.inject};
            shared_res_pkg::OFS_STATUS: state_next.rd = {28'h0000000, state_reg.sts};
            shared_res_pkg::OFS_MASK: state_next.rd = {28'h0000000, state_reg.mask};
            shared_res_pkg::OFS_FLAGS_M2C: state_next.rd = state_reg.hs[0];
            shared_res_pkg::OFS_FLAGS_C2M: state_next.rd = state_reg.hs[1];
            shared_res_pkg::OFS_EOC: state_next.rd = {24'h000000, state_reg.eoc};
            default: begin
               state_next.rd = '0;
               state_next.rresp = shared_res_pkg::RESP_SLVERR;
            end
         endcase
      end
      state_next.awr = !state_next.aw_got && !state_next.bv;
      state_next.wr = !state_next.w_got && !state_next.bv;
      state_next.arr = !state_next.rv;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign m_rsp = state_reg.rsp[0];
   assign c_rsp = state_reg.rsp[1];
   assign control_irq_expander_irq = state_reg.hs[0][shared_res_pkg::IRQ_CH-1:0]; // see R04
   assign master_irq_controller_irq = state_reg.hs[1][shared_res_pkg::IRQ_CH-1:0]; // see R04
   assign ana_out = state_reg.ana;
   assign eoc_master = state_reg.eoc;
   assign eoc_control = state_reg.eoc;
   assign s_axi_awready = state_reg.awr;
   assign s_axi_wready = state_reg.wr;
   assign s_axi_bvalid = state_reg.bv;
   assign s_axi_bresp = state_reg.bresp;
   assign s_axi_arready = state_reg.arr;
   assign s_axi_rvalid = state_reg.rv;
   assign s_axi_rresp = state_reg.rresp;
   assign s_axi_rdata = state_reg.rd;
   assign irq = state_reg.irq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   m2c_ro_a: assert property (c_req.req && !c_rsp.ack && c_req.we && c_req.region == shared_res_pkg::RG_M2C // see R01
      |=> c_rsp.ack && c_rsp.err) else $error("control write to master RAM not refused");
   c2m_ro_a: assert property (m_req.req && !m_rsp.ack && m_req.we && m_req.region == shared_res_pkg::RG_C2M // see R02
      |=> m_rsp.ack && m_rsp.err) else $error("master write to control RAM not refused");
   hs_set_a: assert property (m_req.req && !m_rsp.ack && m_req.we && m_req.region == shared_res_pkg::RG_HS // see R13
      && !m_req.idx[0] |=> (state_reg.hs[0] & $past(m_req.wdata)) == $past(m_req.wdata))
      else $error("handshake flag not set");
   hs_irq_a: assert property (m_req.req && !m_rsp.ack && m_req.we && m_req.region == shared_res_pkg::RG_HS // see R04
      && !m_req.idx[0] && m_req.wdata[0] |=> control_irq_expander_irq[0]) else $error("channel irq missing");
   shr_dir_a: assert property (m_req.req && !m_rsp.ack && m_req.we && m_req.region == shared_res_pkg::RG_SHR // see R05
      && state_reg.dir[m_req.idx[4:2]] |=> m_rsp.err && !$changed(state_reg.mem))
      else $error("shared block written against direction");
   par_fault_a: assert property (m_rsp.ack && m_rsp.err && !m_rsp.fault |-> $past(m_req.we) || // see R12
      $past(m_req.region) >= shared_res_pkg::RG_HS) else $error("master parity error without fault");
   hs_dma_a: assert property (c_req.req && !c_rsp.ack && c_req.dma && c_req.region == shared_res_pkg::RG_HS // see R07
      |=> c_rsp.err && $stable(state_reg.hs)) else $error("control DMA reached handshake");
   ana_res_a: assert property (m_req.req && !m_rsp.ack && !m_req.we && m_req.region == shared_res_pkg::RG_ANA_RES // see R08
      |-> ##[1:4] m_rsp.ack && !m_rsp.err) else $error("result read not served");
   ana_deny_a: assert property (m_req.req && !m_rsp.ack && m_req.region == shared_res_pkg::RG_ANA_REG // see R09
      |=> m_rsp.err && !(ana_out.req && !state_reg.owner)) else $error("master reached analog register");
   ana_one_a: assert property (ana_out.req |=> !ana_out.req ##0 (m_rsp.ack ^ c_rsp.ack) // see R10
      || (m_rsp.ack && c_rsp.ack)) else $error("analog access not single");
   eoc_and_a: assert property (rst_n |=> eoc_master == $past(adc1_eoc & adc2_eoc) // see R11
      && eoc_control == eoc_master) else $error("eoc merge wrong");

   both_ana_c: cover property (m_req.req && c_req.req && m_req.region == shared_res_pkg::RG_ANA_RES
      && c_req.region == shared_res_pkg::RG_ANA_RES ##[1:4] m_rsp.ack ##[1:4] c_rsp.ack);
   par_err_c: cover property (m_rsp.fault);
   hs_round_c: cover property (control_irq_expander_irq[0] ##[1:20] !control_irq_expander_irq[0]);
   irq_c: cover property (irq);
endmodule : shared_res

// [verif/ana_peer.sv]
// Purpose: Analog peripheral stand-in behind the analog common bus.
// Assumes: Reads are answered in the cycle the bus request is high.
// Notes: Idle data lines show the inverse of the last value, so stale data never looks valid.
`timescale 1ns/100ps
module ana_peer (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Bus side
   input shared_res_pkg::ana_req_t ana_in,
   output logic [31:0] ana_rdata,
   // Conversion done levels
   output logic [shared_res_pkg::EOC_N-1:0] adc1_eoc,
   output logic [shared_res_pkg::EOC_N-1:0] adc2_eoc
);
   logic [31:0] regs_reg [0:31];
   logic [31:0] last_reg;
   logic [15:0] ev_reg;
   logic [31:0] val;
   assign val = ana_in.res ? (32'h0a5c_0000 | 32'(ana_in.addr)) : regs_reg[ana_in.addr];
   assign ana_rdata = ana_in.req ? val : ~last_reg;
   assign adc1_eoc = ev_reg[7:0];
   assign adc2_eoc = ev_reg[15:8];
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ev_reg <= 16'h00b5;
         last_reg <= 32'h0;
      end else begin
         ev_reg <= {ev_reg[14:0], ev_reg[15] ^ ev_reg[13] ^ ev_reg[12] ^ ev_reg[10]};
         last_reg <= ana_rdata;
         if (ana_in.req && ana_in.we) regs_reg[ana_in.addr] <= ana_in.wdata;
      end
   end
endmodule : ana_peer

// [verif/dual_core_shared_resources_tb.sv]
// Purpose: Self-checking bench for the shared resource fabric.
// Assumes: Requesters hold req until ack, AXI master waits for every answer.
// Notes: Expected memory, flags and status are kept in a bench-side model.
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dual_core_shared_resources_tb;
   logic mclk, rst_n, irq, er, ft;
   shared_res_pkg::side_req_t m_req, c_req;
   shared_res_pkg::side_rsp_t m_rsp, c_rsp;
   logic [3:0] master_irq_controller_irq, control_irq_expander_irq, s_axi_wstrb, st_exp;
   shared_res_pkg::ana_req_t ana_out;
   logic [31:0] ana_rdata, s_axi_wdata, s_axi_rdata, rnd, d, w;
   logic [7:0] adc1_eoc, adc2_eoc, eoc_master, eoc_control, s_axi_awaddr, s_axi_araddr, dir_exp, p1, p2;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [31:0] mem_exp [0:47];
   int err_count, checked;
   shared_res dut_u (.mclk, .rst_n, .m_req, .c_req, .m_rsp, .c_rsp, .master_irq_controller_irq,
      .control_irq_expander_irq, .ana_out, .ana_rdata, .adc1_eoc, .adc2_eoc, .eoc_master, .eoc_control,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
   ana_peer peer_u (.mclk, .rst_n, .ana_in(ana_out), .ana_rdata, .adc1_eoc, .adc2_eoc);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   function automatic int mi(input logic [2:0] g, input logic [4:0] x);
      return g == shared_res_pkg::RG_M2C ? int'(x[2:0]) : g == shared_res_pkg::RG_C2M ? 8 + int'(x[2:0]) : 16 + int'(x);
   endfunction : mi
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      int n;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hf;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      r = 2'h3;
      for (n = 0; n < 100; n++) begin
         @(posedge mclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            n = 100;
         end
      end
      if (n == 100) err_count++;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      int n;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r = 2'h3;
      v = 32'hx;
      for (n = 0; n < 100; n++) begin
         @(posedge mclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            v = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            n = 100;
         end
      end
      if (n == 100) err_count++;
   endtask : axi_rd
   // Side request held until ack, dropped at the ack edge
   task automatic side_acc(input bit s, we, dma, input logic [2:0] g, input logic [4:0] x,
         input logic [31:0] wd, output logic [31:0] rd, output logic e, output logic f);
      shared_res_pkg::side_req_t q;
      shared_res_pkg::side_rsp_t a;
      int n;
      q = '{1'b1, we, dma, g, x, wd};
      a = '0;
      @(posedge mclk);
      if (s) c_req <= q;
      else m_req <= q;
      for (n = 0; n < 50 && a.ack !== 1'b1; n++) begin
         @(posedge mclk);
         a = s ? c_rsp : m_rsp;
      end
      if (s) c_req <= '0;
      else m_req <= '0;
      rd = a.rdata;
      e = a.err;
      f = a.fault;
   endtask : side_acc
   task automatic op(input bit s, we, dma, input logic [2:0] g, input logic [4:0] x, input logic [31:0] wd,
         input logic xe, input logic [31:0] xr);
      logic [31:0] rd;
      logic e, f;
      side_acc(s, we, dma, g, x, wd, rd, e, f);
      `CHK(e, xe)
      `CHK(f, 1'b0)
      if (!we && !xe) `CHK(rd, xr)
      if (xe) st_exp[2 + s] = 1'b1;
   endtask : op
   task automatic mw(input bit s, input logic [2:0] g, input logic [4:0] x);
      logic ok;
      ok = g == shared_res_pkg::RG_M2C ? !s : g == shared_res_pkg::RG_C2M ? s : dir_exp[x[4:2]] == s;
      op(s, 1'b1, 1'b0, g, x, rnd, !ok, 32'h0);
      if (ok) mem_exp[mi(g, x)] = rnd;
      rnd = lfsr_next(rnd);
   endtask : mw
   task automatic mr(input bit s, input logic [2:0] g, input logic [4:0] x);
      op(s, 1'b0, 1'b0, g, x, 32'h0, 1'b0, mem_exp[mi(g, x)]);
   endtask : mr
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      results();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {m_req, c_req, err_count, checked, st_exp} = '0;
      rnd = 32'h0000_004e;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         axi_rd(8'(i * 4), d, rs);
         `CHK(d, 32'h0)
      end
      axi_rd(8'h40, d, rs);
      `CHK(rs, shared_res_pkg::RESP_SLVERR)
      `CHK(d, 32'h0)
      axi_wr(8'h40, 32'h1, rs);
      `CHK(rs, shared_res_pkg::RESP_SLVERR)
      axi_wr(shared_res_pkg::OFS_MASK, 32'hf, rs);
      dir_exp = rnd[7:0];
      rnd = lfsr_next(rnd);
      axi_wr(shared_res_pkg::OFS_DIR, {24'h0, dir_exp}, rs);
      for (int i = 0; i < 8; i++) begin
         mw(0, shared_res_pkg::RG_M2C, 5'(i));
         mw(1, shared_res_pkg::RG_M2C, 5'(i));
         mr(1, shared_res_pkg::RG_M2C, 5'(i));
         mw(1, shared_res_pkg::RG_C2M, 5'(i));
         mw(0, shared_res_pkg::RG_C2M, 5'(i));
         mr(0, shared_res_pkg::RG_C2M, 5'(i));
      end
      for (int i = 0; i < 32; i++) begin
         mw(0, shared_res_pkg::RG_SHR, 5'(i));
         mw(1, shared_res_pkg::RG_SHR, 5'(i));
         mr(i % 2, shared_res_pkg::RG_SHR, 5'(i));
      end
      op(0, 1'b0, 1'b0, 3'h7, 5'h0, 32'h0, 1'b1, 32'h0);
      axi_rd(shared_res_pkg::OFS_STATUS, d, rs);
      `CHK(d[3:0], st_exp)
      `CHK(irq, 1'b1)
      axi_wr(shared_res_pkg::OFS_STATUS, 32'hf, rs);
      axi_wr(shared_res_pkg::OFS_MASK, 32'h0, rs);
      st_exp = 4'h0;
      mw(1, shared_res_pkg::RG_M2C, 5'h0);
      axi_rd(shared_res_pkg::OFS_STATUS, d, rs);
      `CHK(d[3:0], st_exp)
      `CHK(irq, 1'b0)
      axi_wr(shared_res_pkg::OFS_MASK, 32'hf, rs);
      `CHK(irq, 1'b1)
      axi_wr(shared_res_pkg::OFS_STATUS, 32'hf, rs);
      st_exp = 4'h0;
      // Flags cross both ways; first four mirror onto the far side's interrupts
      for (int s = 0; s < 2; s++) begin
         w = rnd;
         rnd = lfsr_next(rnd);
         op(s, 1'b1, 1'b0, shared_res_pkg::RG_HS, 5'h0, w, 1'b0, 32'h0);
         op(!s, 1'b0, 1'b0, shared_res_pkg::RG_HS, 5'h1, 32'h0, 1'b0, w);
         op(s, 1'b0, 1'b0, shared_res_pkg::RG_HS, 5'h0, 32'h0, 1'b0, w);
         `CHK(s ? master_irq_controller_irq : control_irq_expander_irq, w[3:0])
         axi_rd(s ? shared_res_pkg::OFS_FLAGS_C2M : shared_res_pkg::OFS_FLAGS_M2C, d, rs);
         `CHK(d, w)
         op(!s, 1'b1, 1'b0, shared_res_pkg::RG_HS, 5'h1, w, 1'b0, 32'h0);
         op(s, 1'b0, 1'b0, shared_res_pkg::RG_HS, 5'h0, 32'h0, 1'b0, 32'h0);
         `CHK(s ? master_irq_controller_irq : control_irq_expander_irq, 4'h0)
      end
      op(1, 1'b0, 1'b1, shared_res_pkg::RG_HS, 5'h1, 32'h0, 1'b1, 32'h0);
      op(1, 1'b0, 1'b1, shared_res_pkg::RG_M2C, 5'h3, 32'h0, 1'b0, mem_exp[3]);
      op(0, 1'b0, 1'b1, shared_res_pkg::RG_ANA_RES, 5'h6, 32'h0, 1'b0, 32'h0a5c_0006);
      op(1, 1'b0, 1'b1, shared_res_pkg::RG_ANA_RES, 5'h7, 32'h0, 1'b0, 32'h0a5c_0007);
      op(0, 1'b0, 1'b0, shared_res_pkg::RG_ANA_REG, 5'h3, 32'h0, 1'b1, 32'h0);
      op(1, 1'b0, 1'b1, shared_res_pkg::RG_ANA_REG, 5'h3, 32'h0, 1'b1, 32'h0);
      op(1, 1'b1, 1'b0, shared_res_pkg::RG_ANA_REG, 5'h3, rnd, 1'b0, 32'h0);
      op(0, 1'b1, 1'b0, shared_res_pkg::RG_ANA_RES, 5'h3, rnd, 1'b1, 32'h0);
      fork
         op(0, 1'b0, 1'b0, shared_res_pkg::RG_ANA_RES, 5'h2, 32'h0, 1'b0, 32'h0a5c_0002);
         op(1, 1'b0, 1'b0, shared_res_pkg::RG_ANA_REG, 5'h3, 32'h0, 1'b0, rnd);
      join
      axi_rd(shared_res_pkg::OFS_STATUS, d, rs);
      `CHK(d[3:0], st_exp)
      axi_wr(shared_res_pkg::OFS_STATUS, 32'hf, rs);
      // Parity inverted on store, then read back as an error by both sides, with fault on the master side only
      axi_wr(shared_res_pkg::OFS_CTRL, 32'h1, rs);
      mw(0, shared_res_pkg::RG_M2C, 5'h1);
      axi_wr(shared_res_pkg::OFS_CTRL, 32'h0, rs);
      side_acc(0, 1'b0, 1'b0, shared_res_pkg::RG_M2C, 5'h1, 32'h0, d, er, ft);
      `CHK({er, ft}, 2'h3)
      side_acc(1, 1'b0, 1'b0, shared_res_pkg::RG_M2C, 5'h1, 32'h0, d, er, ft);
      `CHK({er, ft}, 2'h2)
      axi_rd(shared_res_pkg::OFS_STATUS, d, rs);
      `CHK(d[3:0], 4'h3)
      @(posedge mclk);
      p1 = adc1_eoc;
      p2 = adc2_eoc;
      repeat (30) begin
         @(posedge mclk);
         `CHK(eoc_master, p1 & p2)
         `CHK(eoc_control, p1 & p2)
         p1 = adc1_eoc;
         p2 = adc2_eoc;
      end
      results();
   end
endmodule : dual_core_shared_resources_tb
